// File: logic/exec_defines.vh
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH
// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define REG_INSN_OFF     12'h000
`define REG_INSN2_OFF    12'h004
`define REG_FLAGS_OFF    12'h008
`define REG_PC_OFF       12'h00c
`define REG_STAT_OFF     12'h010
`define REG_GPR_BASE     12'h100
`define REG_GPR_LAST     12'h17c
// ---------------------------------------------------------------
// status flag bit positions
// ---------------------------------------------------------------
`define FLG_C 3'd0
`define FLG_Z 3'd1
`define FLG_N 3'd2
`define FLG_V 3'd3
`define FLG_S 3'd4
`define FLG_H 3'd5
`define FLG_T 3'd6
`define FLG_I 3'd7
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_PC    16'h0000
`define RST_FLAGS 8'h00
`endif

// File: logic/branch_move_exec.v
// Functional notes
// - skip next when io bit is one
// - generic flag branch tests selected bit, except bit 4 which tests n xor v
// - branch 1 cycle untaken, 2 taken, no flags
// - equal/not-equal test zero flag
// - carry and unsigned branches test carry
// - negative/positive test negative flag
// - signed branches test n xor v
// - half-carry branches test half-carry flag
// - transfer-bit branches test t flag
// - overflow branches test overflow flag
// - interrupt branches test global enable
// - move, pair copy, immediate: one cycle
// - indirect load, optional post-increment, two cycles
// - pre-decrement load uses decremented pointer
// - displaced load leaves pointer unchanged
// - direct load reads instruction address
// - indirect store, pre-decrement form
// - post-increment store bumps pointer after
// - displaced store, pointer and flags unchanged
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.vh"
module branch_move_exec #(
  parameter DATA_AW = 16
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // data space
  output reg  [15:0] mem_addr,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg  [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  // io bit for skip
  output wire [4:0]  io_addr,
  input  wire [7:0]  io_rdata,
  // state
  output wire        busy
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam S_IDLE = 2'd0;
  localparam S_EXEC = 2'd1;
  localparam S_WAIT = 2'd2;

  reg [7:0]  gpr_q [0:31];
  reg [15:0] insn_q;
  reg [15:0] insn2_q;
  reg [7:0]  flags_q;
  reg [15:0] pc_q;
  reg [1:0]  st_q;
  reg [1:0]  cyc_q;
  reg        taken_q;
  reg [4:0]  ldst_reg_q;
  reg        ld_q;
  reg [15:0] addr_q;
  integer    i;

  // low byte index of each pointer pair; the high byte sits one above
  localparam [4:0] X_LO = 5'd26;
  localparam [4:0] Y_LO = 5'd28;
  localparam [4:0] Z_LO = 5'd30;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // pready stays high: every access finishes in its first access cycle
  // unmapped offsets read zero and ignore writes
  wire wr_acc = psel & penable & pwrite;
  wire in_gpr = (paddr >= `REG_GPR_BASE) && (paddr <= `REG_GPR_LAST);
  wire [4:0] gpr_idx = paddr[6:2];
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign busy    = (st_q != S_IDLE);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // two-word forms: long jump/call and direct load/store
  function is_two_word;
    input [15:0] w;
    begin
      is_two_word = 1'b0;
      // direct load/store: address in the second word
      if ((w[15:10] == 6'b100100) && (w[3:0] == 4'b0000))
        is_two_word = 1'b1;
      // long jump and call: upper address bits in the second word
      if ((w[15:9] == 7'b1001010) && (w[3:2] == 2'b11))
        is_two_word = 1'b1;
    end
  endfunction

  function [15:0] pair;
    input [4:0] lo;
    begin
      pair = {gpr_q[lo + 5'd1], gpr_q[lo]};
    end
  endfunction

  // pointer forms of the indirect group; plain y and z forms decode as displaced
  function is_ptr_mode;
    input [3:0] m;
    begin
      case (m)
        4'hc, 4'hd, 4'he: is_ptr_mode = 1'b1;
        4'h9, 4'ha:       is_ptr_mode = 1'b1;
        4'h1, 4'h2:       is_ptr_mode = 1'b1;
        default:          is_ptr_mode = 1'b0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // operand fields; only those of the decoded form carry meaning
  wire [15:0] w   = insn_q;
  wire [4:0]  rd  = w[8:4];
  wire [4:0]  rr  = {w[9], w[3:0]};
  wire [4:0]  rdi = {1'b1, w[7:4]};
  wire [5:0]  q   = {w[13], w[11:10], w[2:0]};
  wire [15:0] x_p = pair(X_LO);
  wire [15:0] y_p = pair(Y_LO);
  wire [15:0] z_p = pair(Z_LO);
  assign io_addr = w[7:3];

  wire is_skip  = (w[15:8] == 8'h9b);
  wire is_br    = (w[15:11] == 5'b11110);
  wire is_mov   = (w[15:10] == 6'b001011);
  wire is_copy_register_pair  = (w[15:8] == 8'h01);
  wire is_ldi   = (w[15:12] == 4'he);
  wire is_disp  = (w[15:14] == 2'b10) && (w[12] == 1'b0);
  wire is_ldst  = (w[15:10] == 6'b100100);
  wire is_lds   = is_ldst && (w[3:0] == 4'h0) && !w[9];
  wire [1:0] pm = w[1:0];
  wire pre_dec  = (pm == 2'b10);
  wire post_inc = (pm == 2'b01);
  wire [15:0] base = (w[3:2] == 2'b11) ? x_p : (w[3] ? y_p : z_p);
  wire [4:0]  plo  = (w[3:2] == 2'b11) ? X_LO : (w[3] ? Y_LO : Z_LO);
  wire ptr_ok = is_ldst && is_ptr_mode(w[3:0]);

  // ---------------------------------------------------------------
  // pointer arithmetic
  // ---------------------------------------------------------------
  // wraps at 16 bits, the width of a pointer pair
  wire [15:0] ptr_dec = base - 16'd1;
  wire [15:0] ptr_inc = base + 16'd1;

  // ---------------------------------------------------------------
  // branch condition
  // ---------------------------------------------------------------
  // bit w[10] picks set/clear; named branches are aliases of the generic pair
  wire signed_c = flags_q[`FLG_N] ^ flags_q[`FLG_V];
  reg  cond;
  always @* begin
    case (w[2:0])
      `FLG_C:  cond = flags_q[`FLG_C];
      `FLG_Z:  cond = flags_q[`FLG_Z];
      `FLG_N:  cond = flags_q[`FLG_N];
      `FLG_V:  cond = flags_q[`FLG_V];
      `FLG_S:  cond = signed_c;
      `FLG_H:  cond = flags_q[`FLG_H];
      `FLG_T:  cond = flags_q[`FLG_T];
      `FLG_I:  cond = flags_q[`FLG_I];
      default: cond = 1'b0;
    endcase
  end
  wire br_take  = w[10] ? ~cond : cond;
  wire [15:0] br_off = {{9{w[9]}}, w[9:3]};
  wire skip     = io_rdata[w[2:0]];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // exec retires in one clock; loads and stores add a wait clock for data
  // the cycles field reports the instruction's nominal cost, not clocks used
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // the register file clears too, so pointers start from a known value
      for (i = 0; i < 32; i = i + 1)
        gpr_q[i] <= 8'h00;
      insn_q     <= 16'h0000;
      insn2_q    <= 16'h0000;
      flags_q    <= `RST_FLAGS;
      pc_q       <= `RST_PC;
      st_q       <= S_IDLE;
      cyc_q      <= 2'd0;
      taken_q    <= 1'b0;
      ldst_reg_q <= 5'd0;
      ld_q       <= 1'b0;
      addr_q     <= 16'h0000;
      mem_addr   <= 16'h0000;
      mem_rd     <= 1'b0;
      mem_wr     <= 1'b0;
      mem_wdata  <= 8'h00;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // a write to insn launches; the others only preload state
          if (wr_acc) begin
            if (paddr == `REG_INSN_OFF) begin
              insn_q <= pwdata[15:0];
              st_q   <= S_EXEC;
            end else if (paddr == `REG_INSN2_OFF) begin
              insn2_q <= pwdata[15:0];
            end else if (paddr == `REG_FLAGS_OFF) begin
              flags_q <= pwdata[7:0];
            end else if (paddr == `REG_PC_OFF) begin
              pc_q <= pwdata[15:0];
            end else if (in_gpr) begin
              gpr_q[gpr_idx] <= pwdata[7:0];
            end
          end
        end
        S_EXEC: begin
          taken_q <= 1'b0;
          st_q    <= S_IDLE;
          cyc_q   <= 2'd1;
          if (is_skip) begin
            if (skip) begin
              // following word must be preloaded in insn2 to size the skip
              if (is_two_word(insn2_q)) begin
                pc_q  <= pc_q + 16'd3;
                cyc_q <= 2'd3;
              end else begin
                pc_q  <= pc_q + 16'd2;
                cyc_q <= 2'd2;
              end
              taken_q <= 1'b1;
            end else begin
              // bit clear: fall through to the next word
              pc_q <= pc_q + 16'd1;
            end
          end else if (is_br) begin
            // flags untouched on every branch
            if (br_take) begin
              pc_q    <= pc_q + br_off + 16'd1;
              cyc_q   <= 2'd2;
              taken_q <= 1'b1;
            end else begin
              // untaken: one cycle, next word
              pc_q <= pc_q + 16'd1;
            end
          end else if (is_mov) begin
            gpr_q[rd] <= gpr_q[rr];
            pc_q      <= pc_q + 16'd1;
          end else if (is_copy_register_pair) begin
            // both bytes copy in the same clock
            gpr_q[{w[7:4], 1'b0}] <= gpr_q[{w[3:0], 1'b0}];
            gpr_q[{w[7:4], 1'b1}] <= gpr_q[{w[3:0], 1'b1}];
            pc_q <= pc_q + 16'd1;
          end else if (is_ldi) begin
            gpr_q[rdi] <= {w[11:8], w[3:0]};
            pc_q       <= pc_q + 16'd1;
          end else if (is_disp) begin
            // q is zero-extended, so a displacement never reaches backward
            mem_addr   <= (w[3] ? y_p : z_p) + {10'd0, q};
            ld_q       <= ~w[9];
            mem_rd     <= ~w[9];
            mem_wr     <= w[9];
            mem_wdata  <= gpr_q[rd];
            ldst_reg_q <= rd;
            pc_q       <= pc_q + 16'd1;
            cyc_q      <= 2'd2;
            st_q       <= S_WAIT;
          end else if (is_lds) begin
            // second word carries the full 16-bit address
            mem_addr   <= insn2_q;
            mem_rd     <= 1'b1;
            ld_q       <= 1'b1;
            ldst_reg_q <= rd;
            pc_q       <= pc_q + 16'd2;
            cyc_q      <= 2'd2;
            st_q       <= S_WAIT;
          end else if (ptr_ok) begin
            ld_q       <= ~w[9];
            mem_rd     <= ~w[9];
            mem_wr     <= w[9];
            mem_wdata  <= gpr_q[rd];
            ldst_reg_q <= rd;
            pc_q       <= pc_q + 16'd1;
            cyc_q      <= 2'd2;
            st_q       <= S_WAIT;
            // the pointer write lands with the strobe; the access uses old or new value per mode
            if (pre_dec) begin
              mem_addr          <= ptr_dec;
              gpr_q[plo]        <= ptr_dec[7:0];
              gpr_q[plo + 5'd1] <= ptr_dec[15:8];
            end else begin
              mem_addr <= base;
              if (post_inc) begin
                gpr_q[plo]        <= ptr_inc[7:0];
                gpr_q[plo + 5'd1] <= ptr_inc[15:8];
              end
            end
          end else begin
            // anything outside this decoder retires as a one-cycle no-op
            pc_q <= pc_q + 16'd1;
          end
        end
        S_WAIT: begin
          // load data is taken from the bus at the clock edge that ends the strobe cycle
          if (ld_q)
            gpr_q[ldst_reg_q] <= mem_rdata;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // combinational so a read returns in its own access cycle
  always @* begin
    prdata = 32'h00000000;
    if (paddr == `REG_INSN_OFF)
      prdata = {16'h0000, insn_q};
    else if (paddr == `REG_INSN2_OFF)
      prdata = {16'h0000, insn2_q};
    else if (paddr == `REG_FLAGS_OFF)
      prdata = {24'h000000, flags_q};
    else if (paddr == `REG_PC_OFF)
      prdata = {16'h0000, pc_q};
    else if (paddr == `REG_STAT_OFF)
      prdata = {27'h0000000, taken_q, cyc_q, st_q};
    else if (in_gpr)
      prdata = {24'h000000, gpr_q[gpr_idx]};
  end
endmodule // branch_move_exec
`default_nettype wire

// File: bench/exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
module exec_checker (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // core side
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [4:0]  io_addr,
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_launch; psel && penable && pwrite && paddr == 12'h000 && !busy; endsequence
  sequence s_finish; ##[1:2] !busy; endsequence
  property p_zero_wait; psel && penable |-> pready && !pslverr; endproperty
  property p_launch; s_launch |=> busy; endproperty
  property p_cause; $rose(busy) |-> $past(psel) && $past(pwrite) && $past(paddr) == 12'h000; endproperty
  property p_bounded; $rose(busy) |-> s_finish; endproperty
  property p_rd_pulse; mem_rd |=> !mem_rd; endproperty
  property p_wr_pulse; mem_wr |=> !mem_wr; endproperty
  property p_excl; !(mem_rd && mem_wr); endproperty
  // operand select must not move under a running instruction
  property p_io_hold; busy |=> $stable(io_addr); endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("apb access not clean");
  a_launch: assert property (p_launch) else $error("launch did not start");
  a_cause: assert property (p_cause) else $error("busy without launch");
  a_bounded: assert property (p_bounded) else $error("instruction overran");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  a_excl: assert property (p_excl) else $error("read and write together");
  a_io_hold: assert property (p_io_hold) else $error("io select moved");
endmodule // exec_checker
bind branch_move_exec exec_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .mem_rd, .mem_wr, .io_addr, .busy);
`default_nettype wire

// File: bench/data_space_model.sv
`timescale 1ns/1ps
`default_nettype none
module data_space_model (
  input wire logic        pclk,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [4:0]  io_addr,
  output logic [7:0]      mem_rdata,
  output logic [7:0]      io_rdata
);
  logic [7:0] m [0:255];
  logic [7:0] noise = 8'h00;
  logic       rd_d = 1'b0;
  initial for (int i = 0; i < 256; i++) m[i] = i[7:0] ^ 8'h5a;
  always @(posedge pclk) begin
    noise <= noise + 8'h3b;
    rd_d <= mem_rd;
    if (mem_wr) m[mem_addr[7:0]] <= mem_wdata;
  end
  // read data holds one clock past the strobe, then the bus moves, so a later sample never matches by luck
  assign mem_rdata = (mem_rd | rd_d) ? m[mem_addr[7:0]] : noise;
  assign io_rdata = {io_addr, 3'b100};
endmodule // data_space_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, mem_rd, mem_wr, busy;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, io_rdata, f;
  logic [4:0] io_addr;
  logic b, t;
  int bad_count = 0, checks = 0, s, p, v;
  always #12.5 pclk = ~pclk;
  branch_move_exec DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .io_addr, .io_rdata, .busy);
  data_space_model MEM (.pclk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .io_addr, .mem_rdata, .io_rdata);
  task end_sim;
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input [31:0] sn, input [31:0] e);
    checks++;
    if (sn !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, sn);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; psel <= 0; penable <= 0;
  endtask
  task wr(input [11:0] a, input [31:0] d); apb(1, a, d); endtask
  task ck(input string n, input [11:0] a, input [31:0] e); apb(0, a, 0); chk(n, r, e); endtask
  task ex(input [15:0] i, input [15:0] i2, input [1:0] c);
    wr(12'h004, i2); wr(12'h000, i);
    repeat (20) begin apb(0, 12'h010, 0); if (r[1:0] === 2'b00) break; end
    chk("cycles", r[3:2], c);
  endtask
  initial begin #(25 * 20000); bad_count++; end_sim; end
  initial begin
    repeat (5) @(posedge pclk); presetn <= 1;
    ck("pc", 12'h00c, 0); ck("flags", 12'h008, 0); ck("unmapped", 12'hff0, 0);
    // ----------------------------------------
    // every flag, both polarities, backward offset
    // ----------------------------------------
    for (s = 0; s < 8; s++) for (p = 0; p < 2; p++) for (v = 0; v < 2; v++) begin
      f = v ? (8'h01 << s) | (s == 4 ? 8'h04 : 8'h00) : ~(8'h01 << s);
      b = (s == 4) ? f[2] ^ f[3] : f[s];
      t = b ^ p[0];
      wr(12'h008, f); wr(12'h00c, 16);
      ex({5'b11110, p[0], 7'h7e, s[2:0]}, 0, t ? 2 : 1);
      chk("taken", r[4], t);
      ck("pc", 12'h00c, t ? 15 : 17);
      ck("flags", 12'h008, f);
    end
    // ----------------------------------------
    // moves, loads and stores
    // ----------------------------------------
    ex(16'he30c, 0, 1); ck("r16", 12'h140, 8'h3c);
    ex(16'h2e10, 0, 1); ck("r1", 12'h104, 8'h3c);
    wr(12'h144, 8'h7e); ex(16'h0118, 0, 1); ck("r2", 12'h108, 8'h3c); ck("r3", 12'h10c, 8'h7e);
    wr(12'h168, 8'h40); wr(12'h16c, 0); wr(12'h170, 8'h50); wr(12'h174, 0); wr(12'h178, 8'h60); wr(12'h17c, 0);
    ex(16'h905d, 0, 2); ck("r5", 12'h114, 8'h1a); ck("xl", 12'h168, 8'h41);
    ex(16'h905e, 0, 2); ck("r5", 12'h114, 8'h1a); ck("xl", 12'h168, 8'h40);
    ex(16'h806b, 0, 2); ck("r6", 12'h118, 8'h09); ck("yl", 12'h170, 8'h50);
    ex(16'h9070, 16'h0077, 2); ck("r7", 12'h11c, 8'h2d);
    ex(16'h9302, 0, 2); ck("zl", 12'h178, 8'h5f); ex(16'h8080, 0, 2); ck("r8", 12'h120, 8'h3c);
    ex(16'h930d, 0, 2); ck("xl", 12'h168, 8'h41); ex(16'h909e, 0, 2); ck("r9", 12'h124, 8'h3c);
    ex(16'h821a, 0, 2); ck("yl", 12'h170, 8'h50); ex(16'h80aa, 0, 2); ck("r10", 12'h128, 8'h3c);
    ck("flags", 12'h008, 8'h80);
    // ----------------------------------------
    // io bit skip over one and two words
    // ----------------------------------------
    wr(12'h00c, 16); ex(16'h9b0a, 0, 2); ck("pc", 12'h00c, 18);
    wr(12'h00c, 16); ex(16'h9b0a, 16'h9000, 3); ck("pc", 12'h00c, 19);
    wr(12'h00c, 16); ex(16'h9b08, 0, 1); ck("pc", 12'h00c, 17);
    end_sim;
  end
endmodule // testbench
`default_nettype wire
